// ==== hw/seqstk_regs.svh ====
// Offsets, reset values and sizes of the sequencer stack entries six to eight.
// Assumes a 6-bit register address space and 16-bit register words.
`ifndef SEQSTK_REGS_SVH
`define SEQSTK_REGS_SVH

`define SEQSTK_OFS_SIX 6'h26
`define SEQSTK_OFS_SEVEN 6'h27
`define SEQSTK_OFS_EIGHT 6'h28
`define SEQSTK_RST_SIX 16'h4c66
`define SEQSTK_RST_SEVEN 16'h4f77
`define SEQSTK_RST_EIGHT 16'h5000
`define SEQSTK_NUM_ENTRIES 2'h3
`define SEQSTK_DIR_WRITE 1'h1

`endif

// ==== hw/seqstk_pkg.sv ====
// Types shared by the sequencer stack entry bank.
// Assumes 16-bit entries laid out direction, address, return, B, A.
package seqstk_pkg;

  typedef struct packed {
    logic dir;
    logic [5:0] self_address_field;
    logic return_to_first_flag;
    logic [3:0] converter_b_channel_pick;
    logic [3:0] converter_a_channel_pick;
  } seqstk_entry_s;

  typedef struct packed {
    logic [3:0] converter_b_channel_pick;
    logic [3:0] converter_a_channel_pick;
  } seqstk_chan_s;

  typedef enum logic [1:0] {
    SEQSTK_IDLE = 2'b01,
    SEQSTK_CONV = 2'b10
  } seqstk_state_e;

endpackage

// ==== hw/seqstk_entries.sv ====
// Sequencer stack entries six, seven and eight with their step logic.
// Assumes a register master on the plain port and an outer sequencer that
// loads a step, then reports the end of its conversion with one pulse.
`timescale 1ns/10ps
`include "seqstk_regs.svh"

module seqstk_entries (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Register port
  input wire logic [5:0] i_addr,
  input wire seqstk_pkg::seqstk_entry_s i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output seqstk_pkg::seqstk_entry_s o_rdata,
  // Sequencer step port
  input wire logic i_step_load,
  input wire logic [1:0] i_step_sel,
  input wire logic i_conv_done,
  output seqstk_pkg::seqstk_chan_s o_chan,
  output logic o_conv_busy,
  output logic o_step_next,
  output logic o_step_first
);

  seqstk_pkg::seqstk_entry_s stk_q [3];
  seqstk_pkg::seqstk_entry_s rdata_d;
  seqstk_pkg::seqstk_state_e state_q;
  logic ret_q;
  logic load_ok;
  logic rd_hit;

  function automatic logic [5:0] own_addr(input logic [1:0] idx);
    own_addr = `SEQSTK_OFS_SIX + {4'h0, idx};
  endfunction

  function automatic logic [15:0] rst_word(input logic [1:0] idx);
    case (idx)
      2'h0: rst_word = `SEQSTK_RST_SIX;
      2'h1: rst_word = `SEQSTK_RST_SEVEN;
      default: rst_word = `SEQSTK_RST_EIGHT;
    endcase
  endfunction

  // A word is taken only when it names this entry by its own address
  function automatic logic word_hits(input logic [5:0] addr,
                                     input logic [5:0] fld,
                                     input logic [1:0] idx);
    word_hits = (addr == own_addr(idx)) && (fld == own_addr(idx));
  endfunction

  // Entry storage
  for (genvar g = 0; g < 3; g++) begin : g_entry
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        stk_q[g] <= rst_word(2'(g));
      end else if (i_wr && i_wdata.dir == `SEQSTK_DIR_WRITE &&
                   word_hits(i_addr, i_wdata.self_address_field,
                             2'(g))) begin
        stk_q[g] <= i_wdata;
      end
    end
  end

  // Read back: read strobe, or a write word with direction zero
  always_comb begin
    rdata_d = '0;
    rd_hit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (i_rd && i_addr == own_addr(2'(k))) begin
        rdata_d = stk_q[k];
        rd_hit = 1'b1;
      end
      if (i_wr && !i_wdata.dir &&
          word_hits(i_addr, i_wdata.self_address_field,
                    2'(k))) begin
        rdata_d = stk_q[k];
        rd_hit = 1'b1;
      end
    end
  end

  // Unmapped reads answer zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_rd || rd_hit) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= '0;
    end
  end

  // Loads during a conversion are ignored so the running step is not upset
  assign load_ok = i_step_load && (state_q == seqstk_pkg::SEQSTK_IDLE) &&
                   (i_step_sel < `SEQSTK_NUM_ENTRIES);

  // Step state
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_q <= seqstk_pkg::SEQSTK_IDLE;
    end else begin
      case (state_q)
        seqstk_pkg::SEQSTK_IDLE: begin
          if (load_ok) begin
            state_q <= seqstk_pkg::SEQSTK_CONV;
          end
        end
        seqstk_pkg::SEQSTK_CONV: begin
          if (i_conv_done) begin
            state_q <= seqstk_pkg::SEQSTK_IDLE;
          end
        end
        default: state_q <= seqstk_pkg::SEQSTK_IDLE;
      endcase
    end
  end

  // Busy has its own flop so the pin carries no decode behind it
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_conv_busy <= 1'b0;
    end else if (load_ok) begin
      o_conv_busy <= 1'b1;
    end else if (i_conv_done) begin
      o_conv_busy <= 1'b0;
    end
  end

  // Snapshot at load; later edits wait for the next visit
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_chan <= '0;
      ret_q <= 1'b0;
    end else if (load_ok) begin
      o_chan.converter_b_channel_pick <=
        stk_q[i_step_sel].converter_b_channel_pick;
      o_chan.converter_a_channel_pick <=
        stk_q[i_step_sel].converter_a_channel_pick;
      ret_q <= stk_q[i_step_sel].return_to_first_flag;
    end
  end

  // Where to go once the conversion ends
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_step_next <= 1'b0;
      o_step_first <= 1'b0;
    end else begin
      o_step_next <= o_conv_busy && i_conv_done && !ret_q;
      o_step_first <= o_conv_busy && i_conv_done && ret_q;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  chk_write_needs_dir: assert property (
    i_wr && !i_wdata.dir |=> $stable(stk_q[0]) && $stable(stk_q[1]) &&
      $stable(stk_q[2]))
    else $error("entry changed by a read request word");

  chk_addr_field_match: assert property (
    i_wr && i_addr == `SEQSTK_OFS_SIX &&
      i_wdata.self_address_field != `SEQSTK_OFS_SIX |=> $stable(stk_q[0]))
    else $error("entry six written with a foreign address field");

  chk_reset_own_addr: assert property (disable iff (1'b0)
    !i_resetn |=> stk_q[2].self_address_field == `SEQSTK_OFS_EIGHT &&
      stk_q[1].self_address_field == `SEQSTK_OFS_SEVEN)
    else $error("address field not reset to own address");

  chk_advance_next: assert property (
    o_conv_busy && i_conv_done && !ret_q |=> o_step_next && !o_step_first
      ##1 !o_step_next)
    else $error("no single advance pulse after conversion");

  chk_return_first: assert property (
    load_ok && stk_q[i_step_sel].return_to_first_flag ##1
      (!i_conv_done) [*1] ##1 i_conv_done |=> o_step_first && !o_step_next)
    else $error("no return to first entry");

  chk_chan_b_pick: assert property (
    load_ok |=> o_chan.converter_b_channel_pick ==
      $past(stk_q[i_step_sel].converter_b_channel_pick))
    else $error("converter B channel not taken from entry");

  chk_chan_a_pick: assert property (
    load_ok && i_step_sel == 2'h1 |=> o_chan.converter_a_channel_pick ==
      $past(stk_q[1].converter_a_channel_pick))
    else $error("converter A channel not taken from entry");

  chk_reset_six: assert property (disable iff (1'b0)
    !i_resetn |=> stk_q[0] == `SEQSTK_RST_SIX)
    else $error("entry six reset value wrong");

  chk_reset_seven: assert property (disable iff (1'b0)
    !i_resetn |=> stk_q[1] == `SEQSTK_RST_SEVEN && stk_q[1][8])
    else $error("entry seven reset value wrong");

  chk_reset_eight: assert property (disable iff (1'b0)
    !i_resetn |=> stk_q[2] == `SEQSTK_RST_EIGHT)
    else $error("entry eight reset value wrong");

  chk_hold_during_conv: assert property (
    o_conv_busy && !i_conv_done |=> $stable(o_chan) && $stable(ret_q))
    else $error("step settings changed during a conversion");

  // Read data must drop to zero, or a host could take a stale word
  chk_rdata_idle_zero: assert property (
    !i_rd && !rd_hit |=> o_rdata == '0)
    else $error("read data standing without a read");

  chk_read_strobe_data: assert property (
    i_rd && i_addr == `SEQSTK_OFS_SEVEN |=> o_rdata == $past(stk_q[1]))
    else $error("read strobe did not return entry seven");

  chk_read_request_word: assert property (
    i_wr && !i_wdata.dir && i_addr == `SEQSTK_OFS_EIGHT &&
      i_wdata.self_address_field == `SEQSTK_OFS_EIGHT |=>
      o_rdata == $past(stk_q[2]))
    else $error("read request word did not return entry eight");

  chk_write_lands: assert property (
    i_wr && i_wdata.dir && i_addr == `SEQSTK_OFS_SEVEN &&
      i_wdata.self_address_field == `SEQSTK_OFS_SEVEN |=>
      stk_q[1] == $past(i_wdata))
    else $error("matching write word not stored in entry seven");

  chk_write_six_data: assert property (
    i_wr && i_wdata.dir && i_addr == `SEQSTK_OFS_SIX &&
      i_wdata.self_address_field == `SEQSTK_OFS_SIX |=>
      stk_q[0][7:0] == $past(i_wdata[7:0]))
    else $error("channel picks of entry six not stored");

  chk_other_addr_kept: assert property (
    i_wr && i_addr != `SEQSTK_OFS_SEVEN |=> $stable(stk_q[1]))
    else $error("entry seven changed by a write to another address");

  // Only matching words are stored, so each field keeps its own address
  chk_field_own_addr: assert property (
    stk_q[0].self_address_field == `SEQSTK_OFS_SIX &&
      stk_q[1].self_address_field == `SEQSTK_OFS_SEVEN &&
      stk_q[2].self_address_field == `SEQSTK_OFS_EIGHT)
    else $error("an address field left its own address");

  chk_reset_addr_six: assert property (disable iff (1'b0)
    !i_resetn |=> stk_q[0].self_address_field == `SEQSTK_OFS_SIX)
    else $error("entry six address field not reset");

  // Step side checks
  chk_load_starts_busy: assert property (
    load_ok |=> o_conv_busy)
    else $error("accepted step did not start a conversion");

  chk_done_ends_busy: assert property (
    o_conv_busy && i_conv_done |=> !o_conv_busy)
    else $error("conversion end did not clear busy");

  chk_idle_no_pulse: assert property (
    !o_conv_busy |=> !o_step_next && !o_step_first)
    else $error("step pulse without a conversion ending");

  chk_pulse_after_end: assert property (
    o_step_next || o_step_first |-> !o_conv_busy)
    else $error("step pulse while still converting");

  chk_pulses_exclusive: assert property (
    !(o_step_next && o_step_first))
    else $error("advance and return pulsed together");

  chk_ret_snapshot: assert property (
    load_ok |=> ret_q == $past(stk_q[i_step_sel].return_to_first_flag))
    else $error("return flag not taken from the loaded entry");

  chk_chan_eight_pick: assert property (
    load_ok && i_step_sel == 2'h2 |=> o_chan == $past(stk_q[2][7:0]))
    else $error("channel picks not taken from entry eight");

  chk_busy_load_ignored: assert property (
    o_conv_busy && i_step_load && !i_conv_done |=> o_conv_busy &&
      $stable(o_chan) && $stable(ret_q))
    else $error("step load taken during a conversion");

  chk_edit_waits_visit: assert property (
    o_conv_busy && i_wr |=> $stable(o_chan))
    else $error("register edit reached a running conversion");

  cov_write_entry: cover property (
    i_wr && i_wdata.dir ##1 i_rd ##1 o_rdata.dir);
  cov_step_advance: cover property (load_ok ##[1:20] o_step_next);
  cov_step_return: cover property (load_ok ##[1:20] o_step_first);
  cov_edit_in_conv: cover property (o_conv_busy && i_wr && i_wdata.dir);
  cov_load_refused: cover property (o_conv_busy && i_step_load);

endmodule // seqstk_entries

// ==== sim/sequencer_stack_entries_tb.sv ====
// Self-checking bench for sequencer stack entries six to eight.
// Assumes the plain register port and the load/done step handshake.
`timescale 1ns/10ps
`include "seqstk_regs.svh"

module sequencer_stack_entries_tb;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic [5:0] i_addr = 6'h00;
  seqstk_pkg::seqstk_entry_s i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_step_load = 1'b0;
  logic [1:0] i_step_sel = 2'h0;
  logic i_conv_done = 1'b0;
  seqstk_pkg::seqstk_entry_s o_rdata;
  seqstk_pkg::seqstk_chan_s o_chan;
  logic o_conv_busy;
  logic o_step_next;
  logic o_step_first;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  seqstk_entries seqstk_entries_i (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_step_load(i_step_load), .i_step_sel(i_step_sel),
    .i_conv_done(i_conv_done), .o_chan(o_chan),
    .o_conv_busy(o_conv_busy), .o_step_next(o_step_next),
    .o_step_first(o_step_first)
  );

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] w);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= seqstk_pkg::seqstk_entry_s'(w);
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask

  task automatic load(input logic [1:0] s, input logic [7:0] ch,
                      input logic busy);
    @(posedge i_clk_sys);
    i_step_sel <= s;
    i_step_load <= 1'b1;
    @(posedge i_clk_sys);
    i_step_load <= 1'b0;
    #1 check({7'h00, o_conv_busy, o_chan}, {7'h00, busy, ch});
  endtask

  // Pulses stand one cycle, so the second look must see them gone
  task automatic finish(input logic [1:0] fn);
    @(posedge i_clk_sys);
    i_conv_done <= 1'b1;
    @(posedge i_clk_sys);
    i_conv_done <= 1'b0;
    #1 check({13'h0000, o_conv_busy, o_step_first, o_step_next},
             {13'h0000, 1'b0, fn});
    @(posedge i_clk_sys);
    #1 check({14'h0000, o_step_first, o_step_next}, 16'h0000);
  endtask

  // Hang guard, far above the 64 cycles the tests need
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(`SEQSTK_OFS_SIX, `SEQSTK_RST_SIX);
    rd(`SEQSTK_OFS_SEVEN, `SEQSTK_RST_SEVEN);
    rd(`SEQSTK_OFS_EIGHT, `SEQSTK_RST_EIGHT);
    rd(6'h29, 16'h0000);
    $display("test reset values ended");
    wr(6'h26, 16'hcc12);
    rd(6'h26, 16'hcc12);
    wr(6'h26, 16'hce34);
    rd(6'h26, 16'hcc12);
    wr(6'h27, 16'h4e21);
    #1 check(o_rdata, `SEQSTK_RST_SEVEN);
    rd(6'h27, `SEQSTK_RST_SEVEN);
    wr(6'h28, 16'hd0ab);
    rd(6'h28, 16'hd0ab);
    $display("test register access ended");
    load(2'h1, 8'h77, 1'b1);
    finish(2'b10);
    load(2'h0, 8'h12, 1'b1);
    wr(6'h26, 16'hcd9a);
    #1 check({8'h00, o_chan}, 16'h0012);
    load(2'h1, 8'h12, 1'b1);
    finish(2'b01);
    load(2'h0, 8'h9a, 1'b1);
    finish(2'b10);
    finish(2'b00);
    load(2'h3, 8'h9a, 1'b0);
    load(2'h2, 8'hab, 1'b1);
    finish(2'b01);
    $display("test step sequencing ended");
    load(2'h0, 8'h9a, 1'b1);
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    #1 check({7'h00, o_conv_busy, o_chan}, 16'h0000);
    rd(`SEQSTK_OFS_SIX, `SEQSTK_RST_SIX);
    rd(`SEQSTK_OFS_EIGHT, `SEQSTK_RST_EIGHT);
    $display("test mid-run reset ended");
    print_verdict();
  end
endmodule // sequencer_stack_entries_tb
